// ===== pkg/uhcp_regs.vh
`ifndef UHCP_REGS_VH
`define UHCP_REGS_VH

// Byte offsets
`define UHCP_OFF_STRUCT     8'h04
`define UHCP_OFF_CAP        8'h08
`define UHCP_OFF_ROUTE_LO   8'h0c
`define UHCP_OFF_ROUTE_HI   8'h10

// Structural word fields
`define UHCP_NPORTS_LSB     0
`define UHCP_PWRSW_BIT      4
`define UHCP_RRULE_BIT      7
`define UHCP_NPCC_LSB       8
`define UHCP_NCC_LSB        12

// Capability word fields
`define UHCP_WIDE_BIT       0
`define UHCP_PROG_FRAME_LIST_FLAG_BIT       1
`define UHCP_IST_LSB        4

// Reset values
`define UHCP_RST_NPORTS     4'h4
`define UHCP_RST_PWRSW      1'b1
`define UHCP_RST_RRULE      1'b1
`define UHCP_RST_NPCC       4'h2
`define UHCP_RST_NCC        4'h2
`define UHCP_RST_IST        4'h1
`define UHCP_RST_PROG_FRAME_LIST_FLAG       1'b1
`define UHCP_RST_WIDE       1'b0
`define UHCP_RST_ROUTE      60'h000000000001100

// Frame list
`define UHCP_FULL_FRAMES    11'h400

`endif

// ===== core/uhcp_params.v
// How it works
// RQ1: Ports-per-companion times companion count covers the reported port count; with N_CC 0 the code reports companion count 0.
// RQ2: Routing rule 0 maps consecutive port groups to companions, lowest first.
// RQ3: Routing rule 1 maps each port by its route array entry.
// RQ4: Bit 4 reads 1 with power switches, 0 without.
// RQ5: Power-switch bit decides port power field behaviour in port registers.
// RQ6: Bits 3 to 0 of the structural word hold the port count.
// RQ7: Port count sets how many port registers are addressable.
// RQ8: Port count is always 1h through Fh, never zero.
// RQ9: Capability word is a 4-byte register at offset 08h.
// RQ10: Capability word resets to threshold 0001, frame flag 1, width 0.
// RQ11: Threshold top bit 0 gives microframes; 1 means whole frame.
// RQ12: Frame flag 0 forces 1024 entries and read-only zero size field.
// RQ13: Width bit 0 means 32-bit pointers, 1 means 64-bit.
// RQ14: Route array holds 15 four-bit entries, one per port.
// RQ15: Writes to capability registers are ignored.
//
// The implementer's own choice: the Wishbone interface to the registers.
`include "uhcp_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module uhcp_params #(
  parameter [3:0]  N_PORTS     = `UHCP_RST_NPORTS,
  parameter [3:0]  N_CC        = `UHCP_RST_NCC,
  parameter        PWR_SWITCH  = `UHCP_RST_PWRSW,
  parameter        ROUTE_RULE  = `UHCP_RST_RRULE,
  parameter [59:0] ROUTE_INIT  = `UHCP_RST_ROUTE
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output wire        err_o,
  input  wire [3:0]  port_sel_i,
  output reg         port_valid_o,
  output reg  [3:0]  port_companion_o,
  output reg         port_power_ctl_o,
  output reg  [10:0] frame_list_len_o,
  output reg         fls_writable_o,
  output reg  [3:0]  iso_frames_o,
  output reg         iso_whole_frame_o,
  output reg         wide_pointers_o
);

  // Port count clamped into 1..15
  localparam [3:0] NP_EFF  = (N_PORTS == 4'h0) ? 4'h1 : N_PORTS;          // see RQ8
  localparam [3:0] NCC_EFF = (N_CC == 4'h0) ? 4'h1 : N_CC;
  // Smallest group size covering all ports
  localparam integer NPCC_I = (NP_EFF + NCC_EFF - 1) / NCC_EFF;           // see RQ1
  localparam [3:0] NPCC    = NPCC_I[3:0];                                 // see RQ1

  reg  [3:0]  ports_q;
  reg         power_switch_present_q;
  reg         routing_rule_select_q;
  reg  [3:0]  ports_per_companion_q;
  reg  [3:0]  companion_count_q;
  reg  [3:0]  iso_schedule_threshold_q;
  reg         prog_frame_list_flag_q;
  reg         wide_address_capable_q;
  reg  [59:0] companion_route_array_q;
  wire [31:0] struct_w;
  wire [31:0] cap_w;
  wire        req;
  reg  [31:0] rd_d;

  function [3:0] group_of;
    input [3:0] port;
    input [3:0] size;
    begin
      group_of = (size == 4'h0) ? 4'h0 : port / size;
    end
  endfunction

  // Constant contents; writes never alter them
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ports_q                  <= NP_EFF;                               // see RQ6
      power_switch_present_q   <= PWR_SWITCH;                           // see RQ4
      routing_rule_select_q    <= ROUTE_RULE;
      ports_per_companion_q    <= NPCC;                                 // see RQ1
      companion_count_q        <= N_CC;
      iso_schedule_threshold_q <= `UHCP_RST_IST;                        // see RQ10
      prog_frame_list_flag_q   <= `UHCP_RST_PROG_FRAME_LIST_FLAG;                       // see RQ10
      wide_address_capable_q   <= `UHCP_RST_WIDE;                       // see RQ10
      companion_route_array_q  <= ROUTE_INIT;                           // see RQ14
    end
  end

  assign struct_w = {16'h0000, companion_count_q, ports_per_companion_q,
                     routing_rule_select_q, 2'b00, power_switch_present_q, ports_q};
  assign cap_w    = {24'h000000, iso_schedule_threshold_q, 2'b00,
                     prog_frame_list_flag_q, wide_address_capable_q};

  assign req   = cyc_i & stb_i;
  assign err_o = 1'b0;

  // Read mux; unmapped reads return zero
  always @*
  begin
    rd_d = 32'h00000000;
    if (adr_i[7:2] == `UHCP_OFF_STRUCT >> 2)
      rd_d = struct_w;
    else if (adr_i[7:2] == `UHCP_OFF_CAP >> 2)                          // see RQ9
      rd_d = cap_w;
    else if (adr_i[7:2] == `UHCP_OFF_ROUTE_LO >> 2)
      rd_d = companion_route_array_q[31:0];
    else if (adr_i[7:2] == `UHCP_OFF_ROUTE_HI >> 2)
      rd_d = {4'h0, companion_route_array_q[59:32]};
  end

  // Single-cycle ack; writes are acknowledged and dropped
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end
    else
    begin
      ack_o <= req & ~ack_o;
      if (req & ~ack_o & ~we_i)                                         // see RQ15
        dat_o <= rd_d;
    end
  end

  // Capability decode for the rest of the controller
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      port_valid_o      <= 1'b0;
      port_companion_o  <= 4'h0;
      port_power_ctl_o  <= 1'b0;
      frame_list_len_o  <= `UHCP_FULL_FRAMES;
      fls_writable_o    <= 1'b0;
      iso_frames_o      <= 4'h0;
      iso_whole_frame_o <= 1'b0;
      wide_pointers_o   <= 1'b0;
    end
    else
    begin
      port_valid_o     <= port_sel_i < ports_q;                         // see RQ7
      if (routing_rule_select_q && (port_sel_i == 4'hf))
        port_companion_o <= 4'h0;                                       // see RQ14
      else if (routing_rule_select_q)
        port_companion_o <= companion_route_array_q[port_sel_i * 4 +: 4]; // see RQ3
      else
        port_companion_o <= group_of(port_sel_i, ports_per_companion_q);  // see RQ2
      port_power_ctl_o  <= power_switch_present_q;                      // see RQ5
      frame_list_len_o  <= `UHCP_FULL_FRAMES;                           // see RQ12
      fls_writable_o    <= prog_frame_list_flag_q;                      // see RQ12
      iso_whole_frame_o <= iso_schedule_threshold_q[3];                 // see RQ11
      iso_frames_o      <= iso_schedule_threshold_q[3] ? 4'h8 : {1'b0, iso_schedule_threshold_q[2:0]}; // see RQ11
      wide_pointers_o   <= wide_address_capable_q;                      // see RQ13
    end
  end

endmodule // uhcp_params

`default_nettype wire

// ===== test/uhcp_params_checker.sv
`timescale 1ns/1ns
`default_nettype none
module uhcp_params_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [3:0]  port_sel_i,
  input wire logic        port_valid_o,
  input wire logic [3:0]  port_companion_o,
  input wire logic [3:0]  iso_frames_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_rd(a); s_req ##0 !we_i && adr_i == a; endsequence
  chk_ack_once: assert property (s_req |=> ack_o ##1 !ack_o)
    else $error("ack timing");
  chk_cap_word: assert property (s_rd(8'h08) |=> dat_o == 32'h12)
    else $error("cap word");
  chk_port_count: assert property (s_rd(8'h04) |=> dat_o[3:0] != 4'h0 && dat_o[4])
    else $error("port count");
  chk_companion_fit: assert property (s_rd(8'h04) |=> {4'h0, dat_o[11:8]} * dat_o[15:12] >= dat_o[3:0])
    else $error("companion fit");
  chk_write_ignored: assert property (s_req ##0 we_i |=> $stable(dat_o))
    else $error("write changed data");
  chk_port_valid: assert property (1 |=> port_valid_o == ($past(port_sel_i) < 4'h4))
    else $error("port valid");
  chk_route_map: assert property (port_sel_i < 4'h4 |=> port_companion_o == ($past(port_sel_i) >> 1))
    else $error("route map");
  chk_iso_thr: assert property (!$past(rst_i) |-> iso_frames_o == 4'h1)
    else $error("iso threshold");
endmodule // uhcp_params_checker
`default_nettype wire

// ===== test/usb_host_capability_params_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module usb_host_capability_params_tb_top;
  logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [7:0]  adr_i = 0;
  logic [31:0] dat_i = 0, rd;
  logic [3:0]  port_sel_i = 0;
  wire  [31:0] dat_o;
  wire         ack_o, port_valid_o;
  wire  [3:0]  port_companion_o, port_companion0, iso_frames_o;
  wire  [10:0] frame_list_len_o;
  wire         err_o, port_power_ctl_o, fls_writable_o, iso_whole_frame_o, wide_pointers_o;
  int          num_errors = 0, n_compared = 0, cycles = 0;
  logic [7:0]  adr_t [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
  logic [31:0] exp_t [5] = '{32'h2294, 32'h12, 32'h1100, 32'h0, 32'h0};
  uhcp_params dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
    .port_sel_i(port_sel_i), .port_valid_o(port_valid_o), .port_companion_o(port_companion_o),
    .port_power_ctl_o(port_power_ctl_o), .frame_list_len_o(frame_list_len_o),
    .fls_writable_o(fls_writable_o), .iso_frames_o(iso_frames_o),
    .iso_whole_frame_o(iso_whole_frame_o), .wide_pointers_o(wide_pointers_o));
  uhcp_params #(.ROUTE_RULE(1'b0)) dut0_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(1'b0), .stb_i(1'b0),
    .we_i(1'b0), .adr_i(8'h00), .sel_i(4'h0), .dat_i(32'h0), .dat_o(), .ack_o(), .err_o(),
    .port_sel_i(port_sel_i), .port_valid_o(), .port_companion_o(port_companion0),
    .port_power_ctl_o(), .frame_list_len_o(), .fls_writable_o(), .iso_frames_o(),
    .iso_whole_frame_o(), .wide_pointers_o());
  initial forever #5 clk_i = ~clk_i;
  task check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task print_verdict;
    if (num_errors == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= 32'hffffffff;
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      num_errors++;
      print_verdict;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    for (int i = 0; i < 5; i++)
    begin
      wb(1'b1, adr_t[i]);
      wb(1'b0, adr_t[i]);
      check("register", rd, exp_t[i]);
    end
    for (int s = 0; s < 16; s++)
    begin
      port_sel_i <= s[3:0];
      repeat (2) @(posedge clk_i);
      check("valid", {31'h0, port_valid_o}, 32'(s < 4));
      if (s < 4)
        check("route", {28'h0, port_companion_o}, s / 2);
      if (s < 4)
        check("route rule 0", {28'h0, port_companion0}, s / 2);
    end
    check("err", {31'h0, err_o}, 32'h0);
    check("power ctl", {31'h0, port_power_ctl_o}, 32'h1);
    check("frame len", {21'h0, frame_list_len_o}, 32'h400);
    check("fls writable", {31'h0, fls_writable_o}, 32'h1);
    check("iso frames", {28'h0, iso_frames_o}, 32'h1);
    check("iso whole", {31'h0, iso_whole_frame_o}, 32'h0);
    check("wide ptrs", {31'h0, wide_pointers_o}, 32'h0);
    print_verdict;
  end
endmodule // usb_host_capability_params_tb_top
bind uhcp_params uhcp_params_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .port_sel_i(port_sel_i),
  .port_valid_o(port_valid_o), .port_companion_o(port_companion_o), .iso_frames_o(iso_frames_o));
`default_nettype wire
